/* core/bps_pkg.sv */
// Purpose: Shared constants for the backplane parity and signaling access register block
// Assumes: 8-bit register bus, 125 MHz device clock
// Notes: Internal map addresses are the 7-bit indirect space
package bps_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_CLOCK_MON = 8'h3c;
	localparam logic [7:0] ADDR_PARITY = 8'h3d;
	localparam logic [7:0] ADDR_SX_CFG = 8'h40;
	localparam logic [7:0] ADDR_ACCESS_STAT = 8'h41;
	localparam logic [7:0] ADDR_IND_ADDR = 8'h42;
	localparam logic [7:0] ADDR_IND_DATA = 8'h43;
	// Clock monitor fields
	localparam int BIT_RX_BP_SEEN = 1;
	localparam int BIT_RX_LINE_SEEN = 0;
	// Parity register fields
	localparam int BIT_TX_PTYPE = 7;
	localparam int BIT_TX_PIE = 6;
	localparam int BIT_TX_PCM_ERR = 5;
	localparam int BIT_TX_SIG_ERR = 4;
	localparam int BIT_RX_PTYPE = 1;
	localparam int BIT_RX_PINS = 0;
	// Signaling extractor configuration fields
	localparam int BIT_SPEEDUP = 7;
	localparam int BIT_MCOND = 3;
	localparam int BIT_RESV = 2;
	localparam int BIT_INDIR = 1;
	localparam int BIT_SLOT_EN = 0;
	// Access status and indirect control fields
	localparam int BIT_BUSY = 7;
	localparam int BIT_RNW = 7;
	// Per-timeslot configuration fields
	localparam int CFG_INV_HI = 7;
	localparam int CFG_INV_LO = 6;
	localparam int CFG_TKCE = 5;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Internal map regions, selected by address bits 6:5
	localparam logic [1:0] REG_SIG = 2'h1;
	localparam logic [1:0] REG_TCD = 2'h2;
	localparam logic [1:0] REG_CFG = 2'h3;
	localparam logic [4:0] SIG_HOLE = 5'h10;
	// Indirect access latency
	localparam int CLK_MHZ = 125;
	localparam int ACCESS_NS = 480;
	localparam logic [6:0] ACCESS_CYCLES = 7'(ACCESS_NS * CLK_MHZ / 1000);
	// Rx stream bit counter start after the parity position
	localparam logic [7:0] RX_POS_AFTER_START = 8'h01;
endpackage

/* core/bps_regs.sv */
// Purpose: Per-framer clock monitor, backplane parity and signaling extractor access registers
// Assumes: Stream inputs are already in the clock domain and qualified by a bit strobe
// Notes: Monitored clocks are asynchronous pins and pass a two-stage synchroniser
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module bps_regs (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic rx_backplane_clock,
	input wire logic rx_line_clock_input,
	input wire logic tx_bit_valid,
	input wire logic tx_frame_start,
	input wire logic tx_pcm_stream,
	input wire logic tx_signaling_stream,
	output logic interrupt_output_low_n,
	input wire logic rx_bit_valid,
	input wire logic rx_frame_start,
	input wire logic rx_pcm_in,
	input wire logic rx_sig_in,
	input wire logic global_trunk_option,
	input wire logic rx_out_of_frame,
	input wire logic [7:0] idle_code,
	output logic rx_out_valid,
	output logic rx_pcm_stream,
	output logic rx_signaling_stream,
	input wire logic sig_update_valid,
	input wire logic [4:0] sig_update_addr,
	input wire logic [7:0] sig_update_data,
	output logic production_speedup_test,
	output logic per_timeslot_enable
);
	import bps_pkg::*;

	logic bpc_s1_reg, bpc_s2_reg, bpc_s3_reg;
	logic lnc_s1_reg, lnc_s2_reg, lnc_s3_reg;
	logic bp_seen_reg, line_seen_reg;
	logic tx_ptype_reg, tx_pie_reg, tx_pcm_err_reg, tx_sig_err_reg;
	logic rx_ptype_reg, rx_pins_reg;
	logic speedup_reg, mcond_reg, resv_reg, indir_reg, slot_en_reg;
	logic busy_reg;
	logic [6:0] busy_cnt_reg;
	logic [7:0] iac_reg, idata_reg;
	logic tx_primed_reg, tx_pcm_run_reg, tx_sig_run_reg;
	logic [7:0] rx_cnt_reg;
	logic rx_pcm_run_reg, rx_sig_run_reg;
	logic [7:0] sig_mem [32];
	logic [7:0] tcd_mem [32];
	logic [7:0] cfg_mem [32];
	logic [7:0] rdata_next;

	// Register strobes
	wire rd_clk = reg_read && reg_addr == ADDR_CLOCK_MON;
	wire rd_par = reg_read && reg_addr == ADDR_PARITY;
	wire wr_par = reg_write && reg_addr == ADDR_PARITY;
	wire wr_cfg = reg_write && reg_addr == ADDR_SX_CFG;
	wire wr_iac = reg_write && reg_addr == ADDR_IND_ADDR;
	wire wr_idata = reg_write && reg_addr == ADDR_IND_DATA;

	// Rising edges seen on the synchronised clocks, never on the first stage
	wire bp_edge = bpc_s2_reg && !bpc_s3_reg;
	wire line_edge = lnc_s2_reg && !lnc_s3_reg;

	// Two-stage synchronisers plus one history stage for edge detection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{bpc_s1_reg, bpc_s2_reg, bpc_s3_reg} <= 3'h0;
			{lnc_s1_reg, lnc_s2_reg, lnc_s3_reg} <= 3'h0;
		end else begin
			{bpc_s1_reg, bpc_s2_reg, bpc_s3_reg} <= {rx_backplane_clock, bpc_s1_reg, bpc_s2_reg};
			{lnc_s1_reg, lnc_s2_reg, lnc_s3_reg} <= {rx_line_clock_input, lnc_s1_reg, lnc_s2_reg};
		end
	end

	// Activity bits; an edge in the read cycle survives the clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bp_seen_reg <= 1'b0;
			line_seen_reg <= 1'b0;
		end else begin
			bp_seen_reg <= bp_edge || (bp_seen_reg && !rd_clk);
			line_seen_reg <= line_edge || (line_seen_reg && !rd_clk);
		end
	end

	// Tx parity checking at the parity bit position
	// parity position is frame start
	wire tx_check = tx_bit_valid && tx_frame_start && tx_primed_reg;
	wire tx_pcm_exp = tx_pcm_run_reg ^ tx_ptype_reg;
	wire tx_sig_exp = tx_sig_run_reg ^ tx_ptype_reg;
	wire tx_pcm_bad = tx_check && (tx_pcm_stream != tx_pcm_exp);
	wire tx_sig_bad = tx_check && (tx_signaling_stream != tx_sig_exp);

	// Running tx parity; the first frame after reset has no reference and is not checked
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_primed_reg <= 1'b0;
			tx_pcm_run_reg <= 1'b0;
			tx_sig_run_reg <= 1'b0;
		end else if (tx_bit_valid && tx_frame_start) begin
			tx_primed_reg <= 1'b1;
			tx_pcm_run_reg <= 1'b0;
			tx_sig_run_reg <= 1'b0;
		end else if (tx_bit_valid) begin
			tx_pcm_run_reg <= tx_pcm_run_reg ^ tx_pcm_stream;
			tx_sig_run_reg <= tx_sig_run_reg ^ tx_signaling_stream;
		end
	end

	// Parity register and sticky errors; a new error beats the read clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{tx_ptype_reg, tx_pie_reg, rx_ptype_reg, rx_pins_reg} <= 4'h0;
			tx_pcm_err_reg <= 1'b0;
			tx_sig_err_reg <= 1'b0;
		end else begin
			if (wr_par) begin
				tx_ptype_reg <= reg_wdata[BIT_TX_PTYPE];
				tx_pie_reg <= reg_wdata[BIT_TX_PIE];
				rx_ptype_reg <= reg_wdata[BIT_RX_PTYPE];
				rx_pins_reg <= reg_wdata[BIT_RX_PINS];
			end
			tx_pcm_err_reg <= tx_pcm_bad || (tx_pcm_err_reg && !rd_par);
			tx_sig_err_reg <= tx_sig_bad || (tx_sig_err_reg && !rd_par);
		end
	end

	// Interrupt pin, active low, registered
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_output_low_n <= 1'b1;
		end else begin
			interrupt_output_low_n <= !(tx_pie_reg && (tx_pcm_err_reg || tx_sig_err_reg));
		end
	end

	// Signaling extractor configuration; reserved bit is stored but steers nothing
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{speedup_reg, mcond_reg, resv_reg, indir_reg, slot_en_reg} <= 5'h00;
		end else if (wr_cfg) begin
			speedup_reg <= reg_wdata[BIT_SPEEDUP];
			mcond_reg <= reg_wdata[BIT_MCOND];
			resv_reg <= reg_wdata[BIT_RESV];
			indir_reg <= reg_wdata[BIT_INDIR];
			slot_en_reg <= reg_wdata[BIT_SLOT_EN];
		end
	end
	assign production_speedup_test = speedup_reg;
	assign per_timeslot_enable = slot_en_reg;

	// Indirect request decode; a request while busy or with indirect access off is not started
	wire start_req = wr_iac && indir_reg && !busy_reg;
	wire done = busy_reg && busy_cnt_reg == 7'h01;
	wire [6:0] ia = iac_reg[6:0];
	wire [4:0] ia_idx = ia[4:0];
	wire ia_rnw = iac_reg[BIT_RNW];
	wire ia_sig = ia[6:5] == REG_SIG && ia_idx != 5'h00 && ia_idx != SIG_HOLE;
	wire ia_tcd = ia[6:5] == REG_TCD;
	wire ia_cfg = ia[6:5] == REG_CFG;
	wire [7:0] ia_rdata = ia_sig ? sig_mem[ia_idx] : ia_tcd ? tcd_mem[ia_idx] : ia_cfg ? cfg_mem[ia_idx] : 8'h00;

	// Busy flag and latency counter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			busy_cnt_reg <= 7'h00;
		end else if (start_req) begin
			busy_reg <= 1'b1;
			busy_cnt_reg <= ACCESS_CYCLES;
		end else if (busy_reg) begin
			busy_cnt_reg <= busy_cnt_reg - 7'h01;
			busy_reg <= !done;
		end
	end

	// Address/control register; kept stable while an access runs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			iac_reg <= RST_BYTE;
		end else if (wr_iac && !busy_reg) begin
			iac_reg <= reg_wdata;
		end
	end

	// Data buffer: software load, or read result on completion
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			idata_reg <= RST_BYTE;
		end else if (done && ia_rnw) begin
			idata_reg <= ia_rdata;
		end else if (wr_idata) begin
			idata_reg <= reg_wdata;
		end
	end

	// Internal map storage; signaling region is written only by the extractor
	always_ff @(posedge clock) begin
		if (sig_update_valid) begin
			sig_mem[sig_update_addr] <= sig_update_data;
		end
		if (done && !ia_rnw && ia_tcd) begin
			tcd_mem[ia_idx] <= idata_reg;
		end
		if (done && !ia_rnw && ia_cfg) begin
			cfg_mem[ia_idx] <= idata_reg;
		end
	end

	// Rx stream position; frame start marks bit 1 of TS0
	wire [7:0] rx_pos = rx_frame_start ? 8'h00 : rx_cnt_reg;
	wire [4:0] rx_ts = rx_pos[7:3];
	wire [2:0] rx_bit = rx_pos[2:0];
	wire [2:0] rx_sel = 3'h7 - rx_bit;
	wire [7:0] ts_cfg = cfg_mem[rx_ts];
	wire [7:0] ts_tcd = tcd_mem[rx_ts];
	wire ts_tkce = slot_en_reg && ts_cfg[CFG_TKCE];
	wire [1:0] ts_inv = slot_en_reg ? ts_cfg[CFG_INV_HI:CFG_INV_LO] : 2'h0;
	wire ts_cond = mcond_reg || ts_tkce;
	// Inversion: 01 flips even bits (odd index), 10 flips odd bits (even index)
	wire inv_bit = rx_bit[0] ? ts_inv[0] : ts_inv[1];
	wire pcm_proc = ts_cond ? ts_tcd[rx_sel] : (global_trunk_option && rx_out_of_frame) ? idle_code[rx_sel] :
		rx_pcm_in ^ inv_bit;
	// Signaling nibble sits in bits 5 to 8 of the slot
	// conditioned signaling bits
	wire sig_proc = (ts_cond && rx_bit[2]) ? ts_cfg[rx_sel] : rx_sig_in;
	// parity type selects even or odd
	wire rx_pcm_par = rx_pcm_run_reg ^ rx_ptype_reg;
	wire rx_sig_par = rx_sig_run_reg ^ rx_ptype_reg;
	wire pcm_out = (rx_frame_start && rx_pins_reg) ? rx_pcm_par : pcm_proc;
	wire sig_out = (rx_frame_start && rx_pins_reg) ? rx_sig_par : sig_proc;

	// Rx counter and running parity over the bits actually sent
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt_reg <= 8'h00;
			rx_pcm_run_reg <= 1'b0;
			rx_sig_run_reg <= 1'b0;
		end else if (rx_bit_valid && rx_frame_start) begin
			rx_cnt_reg <= RX_POS_AFTER_START;
			rx_pcm_run_reg <= 1'b0;
			rx_sig_run_reg <= 1'b0;
		end else if (rx_bit_valid) begin
			rx_cnt_reg <= rx_cnt_reg + 8'h01;
			rx_pcm_run_reg <= rx_pcm_run_reg ^ pcm_out;
			rx_sig_run_reg <= rx_sig_run_reg ^ sig_out;
		end
	end

	// Rx stream outputs, one cycle behind the input bit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_out_valid <= 1'b0;
			rx_pcm_stream <= 1'b0;
			rx_signaling_stream <= 1'b0;
		end else begin
			rx_out_valid <= rx_bit_valid;
			if (rx_bit_valid) begin
				rx_pcm_stream <= pcm_out;
				rx_signaling_stream <= sig_out;
			end
		end
	end

	// Read mux; unmapped addresses and unused bits read zero
	always_comb begin
		rdata_next = 8'h00;
		unique case (reg_addr)
			ADDR_CLOCK_MON: begin
				rdata_next[BIT_RX_BP_SEEN] = bp_seen_reg;
				rdata_next[BIT_RX_LINE_SEEN] = line_seen_reg;
			end
			ADDR_PARITY: begin
				rdata_next[BIT_TX_PTYPE] = tx_ptype_reg;
				rdata_next[BIT_TX_PIE] = tx_pie_reg;
				rdata_next[BIT_TX_PCM_ERR] = tx_pcm_err_reg;
				rdata_next[BIT_TX_SIG_ERR] = tx_sig_err_reg;
				rdata_next[BIT_RX_PTYPE] = rx_ptype_reg;
				rdata_next[BIT_RX_PINS] = rx_pins_reg;
			end
			ADDR_SX_CFG: begin
				rdata_next[BIT_SPEEDUP] = speedup_reg;
				rdata_next[BIT_MCOND] = mcond_reg;
				rdata_next[BIT_RESV] = resv_reg;
				rdata_next[BIT_INDIR] = indir_reg;
				rdata_next[BIT_SLOT_EN] = slot_en_reg;
			end
			ADDR_ACCESS_STAT: rdata_next[BIT_BUSY] = busy_reg;
			ADDR_IND_ADDR: rdata_next = iac_reg;
			ADDR_IND_DATA: rdata_next = idata_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// Read data register; holds only in the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_read ? rdata_next : 8'h00;
		end
	end

	// Checks
	property p_bp_seen;
		@(posedge clock) disable iff (!rst_n) bp_edge |=> bp_seen_reg;
	endproperty
	a_bp_seen: assert property (p_bp_seen) else $error("backplane clock edge not recorded");

	property p_line_clear;
		@(posedge clock) disable iff (!rst_n) (rd_clk && !line_edge) |=> !line_seen_reg;
	endproperty
	a_line_clear: assert property (p_line_clear) else $error("line clock seen bit not cleared by read");

	property p_tx_err;
		@(posedge clock) disable iff (!rst_n)
			(tx_check && tx_pcm_stream != (tx_pcm_run_reg ^ tx_ptype_reg)) |=> tx_pcm_err_reg ##1 !interrupt_output_low_n == tx_pie_reg;
	endproperty
	a_tx_err: assert property (p_tx_err) else $error("pcm parity error not reported");

	property p_int_gate;
		@(posedge clock) disable iff (!rst_n) !tx_pie_reg |=> interrupt_output_low_n;
	endproperty
	a_int_gate: assert property (p_int_gate) else $error("interrupt asserted while disabled");

	property p_sig_sticky;
		@(posedge clock) disable iff (!rst_n) (tx_sig_err_reg && !rd_par) |=> tx_sig_err_reg;
	endproperty
	a_sig_sticky: assert property (p_sig_sticky) else $error("signaling parity error lost");

	property p_rx_insert;
		@(posedge clock) disable iff (!rst_n)
			(rx_bit_valid && rx_frame_start && rx_pins_reg) |=> rx_pcm_stream == $past(rx_pcm_run_reg ^ rx_ptype_reg);
	endproperty
	a_rx_insert: assert property (p_rx_insert) else $error("wrong inserted rx parity");

	property p_rx_pass;
		@(posedge clock) disable iff (!rst_n)
			(rx_bit_valid && rx_frame_start && !rx_pins_reg && !ts_cond && !rx_sig_in) |=> !rx_signaling_stream;
	endproperty
	a_rx_pass: assert property (p_rx_pass) else $error("rx parity position altered while disabled");

	property p_busy_len;
		@(posedge clock) disable iff (!rst_n) start_req |=> busy_reg [*8] ##52 busy_reg ##1 !busy_reg;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

	property p_read_load;
		@(posedge clock) disable iff (!rst_n) (done && ia_rnw) |=> idata_reg == $past(ia_rdata);
	endproperty
	a_read_load: assert property (p_read_load) else $error("indirect read result not loaded");

	property p_no_start;
		@(posedge clock) disable iff (!rst_n) (wr_iac && !indir_reg && !busy_reg) |=> !busy_reg;
	endproperty
	a_no_start: assert property (p_no_start) else $error("access started with indirect mode off");

	c_tx_err: cover property (@(posedge clock) disable iff (!rst_n) tx_pcm_bad ##1 rd_par);
	c_ind_read: cover property (@(posedge clock) disable iff (!rst_n) (start_req && reg_wdata[BIT_RNW]) ##[1:70] done);
	c_cond: cover property (@(posedge clock) disable iff (!rst_n) rx_bit_valid && ts_cond);
	c_clock_seen: cover property (@(posedge clock) disable iff (!rst_n) bp_edge ##[1:20] rd_clk);
endmodule

/* testbench/bps_far_model.sv */
// Purpose: Far-side stream source for the tx and rx backplane streams
// Assumes: One bit per clock; every signal changes just after a rising edge
// Notes: Short frames (tx 16 bits, rx 24 bits) keep the run brief
`timescale 1ns/1ps
module bps_far_model (
	input wire logic clock,
	output logic tx_bit_valid,
	output logic tx_frame_start,
	output logic tx_pcm_stream,
	output logic tx_signaling_stream,
	output logic rx_bit_valid,
	output logic rx_frame_start,
	output logic rx_pcm_in,
	output logic rx_sig_in
);
	logic par_pcm = 1'b0;
	logic par_sig = 1'b0;

	// Single-rail streams only; the two-rail option stays cleared
	// Quiet lines at time zero
	initial begin
		tx_bit_valid = 1'b0;
		tx_frame_start = 1'b0;
		tx_pcm_stream = 1'b0;
		tx_signaling_stream = 1'b1;
		rx_bit_valid = 1'b0;
		rx_frame_start = 1'b0;
		rx_pcm_in = 1'b0;
		rx_sig_in = 1'b1;
	end

	// parity of previous frame
	// A forced error flips the parity bit; data lines toggle after the frame so no stale value lingers
	task automatic tx_frame(input logic odd, input logic bad_pcm, input logic bad_sig);
		logic b;
		@(posedge clock);
		tx_bit_valid <= 1'b1;
		tx_frame_start <= 1'b1;
		tx_pcm_stream <= par_pcm ^ odd ^ bad_pcm;
		tx_signaling_stream <= par_sig ^ odd ^ bad_sig;
		par_pcm = 1'b0;
		par_sig = 1'b0;
		for (int i = 1; i < 16; i++) begin
			@(posedge clock);
			b = (i % 3) == 0;
			tx_frame_start <= 1'b0;
			tx_pcm_stream <= b;
			tx_signaling_stream <= ~b;
			par_pcm = par_pcm ^ b;
			par_sig = par_sig ^ ~b;
		end
		@(posedge clock);
		tx_bit_valid <= 1'b0;
		tx_pcm_stream <= ~tx_pcm_stream;
		tx_signaling_stream <= ~tx_signaling_stream;
	endtask

	// Receive frame, first bit is the parity position, most significant bit first
	task automatic rx_frame(input logic [23:0] pcm, input logic [23:0] sig);
		for (int i = 0; i < 24; i++) begin
			@(posedge clock);
			rx_bit_valid <= 1'b1;
			rx_frame_start <= (i == 0);
			rx_pcm_in <= pcm[23 - i];
			rx_sig_in <= sig[23 - i];
		end
		@(posedge clock);
		rx_bit_valid <= 1'b0;
		rx_frame_start <= 1'b0;
		rx_pcm_in <= ~rx_pcm_in;
		rx_sig_in <= ~rx_sig_in;
	endtask
endmodule

/* testbench/bps_regs_bench.sv */
// Purpose: Self-checking bench for the parity and signaling access registers
// Assumes: Register bus with read data one cycle after the strobe
// Notes: Indirect accesses are polled on the busy bit with a bounded count
`timescale 1ns/1ps
module bps_regs_bench;
	import bps_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic rx_backplane_clock = 1'b0;
	logic rx_line_clock_input = 1'b0;
	logic tx_bit_valid, tx_frame_start, tx_pcm_stream, tx_signaling_stream;
	logic rx_bit_valid, rx_frame_start, rx_pcm_in, rx_sig_in;
	logic interrupt_output_low_n, rx_out_valid, rx_pcm_stream, rx_signaling_stream;
	logic global_trunk_option = 1'b0;
	logic rx_out_of_frame = 1'b0;
	logic [7:0] idle_code = 8'hc3;
	logic sig_update_valid = 1'b0;
	logic [4:0] sig_update_addr = 5'h00;
	logic [7:0] sig_update_data = 8'h00;
	logic production_speedup_test, per_timeslot_enable;
	logic [23:0] cap_pcm = 24'h000000;
	logic [23:0] cap_sig = 24'h000000;
	int failures = 0;
	int checks_done = 0;

	bps_regs uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.rx_backplane_clock(rx_backplane_clock), .rx_line_clock_input(rx_line_clock_input),
		.tx_bit_valid(tx_bit_valid), .tx_frame_start(tx_frame_start), .tx_pcm_stream(tx_pcm_stream),
		.tx_signaling_stream(tx_signaling_stream), .interrupt_output_low_n(interrupt_output_low_n),
		.rx_bit_valid(rx_bit_valid), .rx_frame_start(rx_frame_start), .rx_pcm_in(rx_pcm_in),
		.rx_sig_in(rx_sig_in), .global_trunk_option(global_trunk_option),
		.rx_out_of_frame(rx_out_of_frame), .idle_code(idle_code), .rx_out_valid(rx_out_valid),
		.rx_pcm_stream(rx_pcm_stream), .rx_signaling_stream(rx_signaling_stream),
		.sig_update_valid(sig_update_valid), .sig_update_addr(sig_update_addr),
		.sig_update_data(sig_update_data), .production_speedup_test(production_speedup_test),
		.per_timeslot_enable(per_timeslot_enable));

	bps_far_model far (.clock(clock), .tx_bit_valid(tx_bit_valid), .tx_frame_start(tx_frame_start),
		.tx_pcm_stream(tx_pcm_stream), .tx_signaling_stream(tx_signaling_stream),
		.rx_bit_valid(rx_bit_valid), .rx_frame_start(rx_frame_start), .rx_pcm_in(rx_pcm_in),
		.rx_sig_in(rx_sig_in));

	// 125 MHz clock
	initial begin
		forever #4 clock = ~clock;
	end

	// Shift in processed rx bits, first bit ends up at the top
	always @(posedge clock) begin
		if (rx_out_valid === 1'b1) begin
			cap_pcm <= {cap_pcm[22:0], rx_pcm_stream};
			cap_sig <= {cap_sig[22:0], rx_signaling_stream};
		end
	end

	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		// Data stand in this cycle; take them at the edge that ends it
		@(posedge clock);
		d = reg_rdata;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		bus_read(a, d);
		check(what, 24'(d), 24'(exp));
	endtask

	// Start an indirect access and poll busy; busy must show at once and clear in bounded time
	task automatic ind_go(input logic [7:0] ctl);
		logic [7:0] s;
		int n;
		bus_write(ADDR_IND_ADDR, ctl);
		bus_read(ADDR_ACCESS_STAT, s);
		check("busy at start", 24'(s), 24'h80);
		n = 0;
		// poll busy low before the next request
		while (s[BIT_BUSY] !== 1'b0 && n < 100) begin
			bus_read(ADDR_ACCESS_STAT, s);
			n++;
		end
		check("busy cleared", 24'(s), 24'h0);
	endtask

	task automatic rx_run(input logic [23:0] pcm, input logic [23:0] sig);
		far.rx_frame(pcm, sig);
		repeat (2) @(posedge clock);
	endtask

	task automatic t_reset();
		rd_chk("parity reg", ADDR_PARITY, 8'h00);
		rd_chk("config reg", ADDR_SX_CFG, 8'h00);
		rd_chk("access stat", ADDR_ACCESS_STAT, 8'h00);
		rd_chk("clock mon", ADDR_CLOCK_MON, 8'h00);
		check("cfg outs", {22'h0, production_speedup_test, per_timeslot_enable}, 24'h0);
		check("int idle", 24'(interrupt_output_low_n), 24'h1);
		$display("test reset done");
	endtask

	task automatic t_clkmon();
		repeat (2) begin
			rx_backplane_clock <= 1'b1;
			repeat (4) @(posedge clock);
			rx_backplane_clock <= 1'b0;
			repeat (4) @(posedge clock);
		end
		rd_chk("bp clock seen", ADDR_CLOCK_MON, 8'h02);
		rd_chk("bp clock cleared", ADDR_CLOCK_MON, 8'h00);
		rx_line_clock_input <= 1'b1;
		repeat (4) @(posedge clock);
		rx_line_clock_input <= 1'b0;
		repeat (4) @(posedge clock);
		rd_chk("line clock seen", ADDR_CLOCK_MON, 8'h01);
		rd_chk("line clock cleared", ADDR_CLOCK_MON, 8'h00);
		$display("test clock monitor done");
	endtask

	task automatic t_cfg();
		bus_write(ADDR_SX_CFG, 8'h81);
		@(posedge clock);
		check("cfg outs", {22'h0, production_speedup_test, per_timeslot_enable}, 24'h3);
		rd_chk("config rb", ADDR_SX_CFG, 8'h81);
		// test bit back to zero at once
		bus_write(ADDR_SX_CFG, 8'h00);
		bus_write(ADDR_ACCESS_STAT, 8'hff);
		rd_chk("stat ro", ADDR_ACCESS_STAT, 8'h00);
		bus_write(8'h50, 8'hff);
		rd_chk("unmapped", 8'h50, 8'h00);
		bus_write(ADDR_IND_ADDR, 8'h45);
		rd_chk("no start ind off", ADDR_ACCESS_STAT, 8'h00);
		rd_chk("addr stored", ADDR_IND_ADDR, 8'h45);
		$display("test config done");
	endtask

	task automatic t_txpar();
		bus_write(ADDR_PARITY, 8'h40);
		far.tx_frame(1'b0, 1'b0, 1'b0);
		far.tx_frame(1'b0, 1'b0, 1'b0);
		rd_chk("even good", ADDR_PARITY, 8'h40);
		far.tx_frame(1'b0, 1'b1, 1'b0);
		repeat (2) @(posedge clock);
		check("int low", 24'(interrupt_output_low_n), 24'h0);
		rd_chk("pcm err", ADDR_PARITY, 8'h60);
		repeat (2) @(posedge clock);
		check("int released", 24'(interrupt_output_low_n), 24'h1);
		rd_chk("pcm err cleared", ADDR_PARITY, 8'h40);
		bus_write(ADDR_PARITY, 8'h80);
		far.tx_frame(1'b1, 1'b0, 1'b0);
		rd_chk("odd good", ADDR_PARITY, 8'h80);
		far.tx_frame(1'b1, 1'b0, 1'b1);
		repeat (2) @(posedge clock);
		check("int masked", 24'(interrupt_output_low_n), 24'h1);
		rd_chk("sig err", ADDR_PARITY, 8'h90);
		rd_chk("sig err cleared", ADDR_PARITY, 8'h80);
		$display("test tx parity done");
	endtask

	task automatic t_indirect();
		bus_write(ADDR_SX_CFG, 8'h02);
		bus_write(ADDR_IND_DATA, 8'ha5);
		ind_go(8'h41);
		bus_write(ADDR_IND_DATA, 8'h3c);
		ind_go(8'h42);
		bus_write(ADDR_IND_DATA, 8'h00);
		ind_go(8'hc1);
		rd_chk("cond byte read", ADDR_IND_DATA, 8'ha5);
		@(posedge clock);
		sig_update_valid <= 1'b1;
		sig_update_addr <= 5'h01;
		sig_update_data <= 8'h3c;
		@(posedge clock);
		sig_update_valid <= 1'b0;
		bus_write(ADDR_IND_DATA, 8'hff);
		ind_go(8'h21);
		ind_go(8'ha1);
		rd_chk("signaling read", ADDR_IND_DATA, 8'h3c);
		ind_go(8'hb0);
		rd_chk("hole read", ADDR_IND_DATA, 8'h00);
		$display("test indirect done");
	endtask

	task automatic t_rx();
		bus_write(ADDR_PARITY, 8'h01);
		// First frame after reset: running parity starts at zero
		rx_run(24'h5a3c81, 24'h13579b);
		check("rx first", cap_pcm, 24'h5a3c81);
		rx_run(24'h2468ac, 24'h0f0f0f);
		check("rx even pcm", cap_pcm, {^(23'h5a3c81), 23'h2468ac});
		check("rx even sig", cap_sig, {^(23'h13579b), 23'h0f0f0f});
		bus_write(ADDR_PARITY, 8'h03);
		rx_run(24'h7e0011, 24'h33cc55);
		check("rx odd pcm", cap_pcm, {~^(23'h2468ac), 23'h7e0011});
		bus_write(ADDR_PARITY, 8'h02);
		// Inserted odd parity would be one here, the input bit is zero
		rx_run(24'h7f00ff, 24'h33cc55);
		check("rx no insert", cap_pcm, 24'h7f00ff);
		// Slot 1 inverts bits 2,4,6,8; slot 2 is conditioned with signaling nibble 9
		bus_write(ADDR_IND_DATA, 8'h40);
		ind_go(8'h61);
		bus_write(ADDR_IND_DATA, 8'h29);
		ind_go(8'h62);
		bus_write(ADDR_SX_CFG, 8'h03);
		rx_run(24'h123456, 24'h00fff0);
		check("slot invert", 24'(cap_pcm[15:0]), 24'h00613c);
		check("slot sig cond", 24'(cap_sig[15:0]), 24'h00fff9);
		global_trunk_option <= 1'b1;
		rx_out_of_frame <= 1'b1;
		bus_write(ADDR_SX_CFG, 8'h0a);
		rx_run(24'h123456, 24'h000000);
		check("master cond", 24'(cap_pcm[15:0]), 24'h00a53c);
		check("master sig", 24'(cap_sig[15:0]), 24'h000009);
		bus_write(ADDR_SX_CFG, 8'h02);
		rx_run(24'h123456, 24'h000000);
		check("idle code", 24'(cap_pcm[15:0]), 24'h00c3c3);
		global_trunk_option <= 1'b0;
		rx_out_of_frame <= 1'b0;
		$display("test rx stream done");
	endtask

	// Reset in mid-run must drop the configuration and parity register bits set before it; per-timeslot map bytes have no reset
	task automatic t_midreset();
		bus_write(ADDR_SX_CFG, 8'h0b);
		bus_write(ADDR_PARITY, 8'hc3);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rd_chk("cfg after reset", ADDR_SX_CFG, 8'h00);
		rd_chk("parity after reset", ADDR_PARITY, 8'h00);
		check("outs after reset", {22'h0, production_speedup_test, per_timeslot_enable}, 24'h0);
		$display("test mid-run reset done");
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence after a four-cycle reset
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_clkmon();
		t_cfg();
		t_txpar();
		t_indirect();
		t_rx();
		t_midreset();
		give_verdict();
	end

	// Watchdog, far beyond the thousand or so cycles the tests need
	initial begin
		#100000;
		failures++;
		give_verdict();
	end
endmodule
